// ### vc1rc_control.sv
// Control register of the second virtual channel, on the configuration access port.
//
// Contract
// - Writing one to channel enable starts negotiation and raises negotiation pending.
// - Channel enable is read/write and resets cleared.
// - Channel identifier resets to 001b and is rewritable.
// - Arbitration scheme select is read/write and names a capability bit position.
// - Select 000 is fixed round-robin at reset; 100 is time-based WRR 128.
// - Writing one to load-table copies programmed entries into active tables.
// - Load-table bit is a trigger and always reads zero.
// - Traffic class map has one bit per class; one means carried here.
// - Traffic class zero map bit is read-only zero; bits one to seven writable.
// - Traffic class map resets to all zeros.
// - Reserved ranges read zero and ignore writes.
// - Register sits at offset 170h and resets to 0100 0000h.
// - Negotiation pending stays set while negotiation is in progress.
// - Table status clears when a requested table load completes.
module vc1rc_control
   import vc1rc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        cfg_write,
   input  wire logic        cfg_read,
   input  wire logic [11:0] cfg_addr,
   input  wire logic [3:0]  cfg_byte_en,
   input  wire logic [31:0] cfg_wdata,
   output logic [31:0]      cfg_rdata,
   output logic             cfg_ack,
   input  wire logic        table_modified,
   output logic             channel_enable,
   output logic [2:0]       channel_identifier,
   output logic [2:0]       arbitration_scheme_select,
   output logic [7:0]       traffic_class_map,
   output logic             negotiation_pending,
   output logic             table_status,
   output logic             table_load_strobe
);

   // Requests are taken on one edge and answered on the next; back-to-back requests are allowed.
   // State of the block: writable fields, the table status flag, the two trigger pulses, the acknowledge and the read data.
   typedef struct packed {
      logic        enable;
      logic [2:0]  ident;
      logic [2:0]  sel;
      logic [7:0]  map;
      logic        tstat;
      logic        load;
      logic        neg_start;
      logic        ack;
      logic [31:0] rdata;
   } vc1rc_state_t;

   vc1rc_state_t s_q;
   vc1rc_state_t s_d;
   // Timer outputs, decode hits and the read views of the two words.
   logic         neg_busy;
   logic         load_done;
   logic         hit_ctrl;
   logic         hit_stat;
   logic [31:0]  ctrl_view;
   logic [31:0]  stat_view;

   // Qualified requests, byte lanes and field slices of the write data.
   logic         wr_ctrl;
   logic         rd_ctrl;
   logic         rd_stat;
   logic         wr_lane3;
   logic         wr_lane2;
   logic         wr_lane0;
   logic         wr_enable;
   logic         wr_load;
   logic [2:0]   wr_ident;
   logic [2:0]   wr_sel;
   logic [7:0]   wr_map;

   // Address decode of the two registers.
   always_comb begin
      hit_ctrl = 1'b0;
      hit_stat = 1'b0;
      if (cfg_addr == VC1RC_CTRL_OFFSET) begin
         hit_ctrl = 1'b1;
      end else if (cfg_addr == VC1RC_STATUS_OFFSET) begin
         hit_stat = 1'b1;
      end
   end

   // Read views of the control word and the status word; every unlisted bit stays zero.
   // reserved read zero
   always_comb begin
      ctrl_view = '0;
      ctrl_view[VC1RC_EN_BIT] = s_q.enable;
      ctrl_view[VC1RC_ID_LSB +: 3] = s_q.ident;
      ctrl_view[VC1RC_SEL_LSB +: 3] = s_q.sel;
      ctrl_view[7:0] = s_q.map;
      // Status word: pending and table status in the upper half.
      stat_view = '0;
      stat_view[VC1RC_PEND_BIT] = neg_busy;
      stat_view[VC1RC_TSTAT_BIT] = s_q.tstat;
   end

   // Access qualifiers: which register a request hits and which byte lanes a write carries.
   always_comb begin
      wr_ctrl  = cfg_write & hit_ctrl;
      rd_ctrl  = cfg_read & hit_ctrl;
      rd_stat  = cfg_read & hit_stat;
      wr_lane3 = wr_ctrl & cfg_byte_en[3];
      wr_lane2 = wr_ctrl & cfg_byte_en[2];
      wr_lane0 = wr_ctrl & cfg_byte_en[0];
   end

   // Field slices of the write data, with the fixed class zero bit masked off.
   // class zero fixed
   always_comb begin
      wr_enable = cfg_wdata[VC1RC_EN_BIT];
      wr_ident  = cfg_wdata[VC1RC_ID_LSB +: 3];
      wr_sel    = cfg_wdata[VC1RC_SEL_LSB +: 3];
      wr_load   = cfg_wdata[VC1RC_LOAD_BIT];
      wr_map    = cfg_wdata[7:0] & VC1RC_MAP_WMASK;
   end

   // Register update for writes, triggers and read data.
   always_comb begin
      s_d           = s_q;
      s_d.load      = 1'b0;
      s_d.neg_start = 1'b0;
      // Every request is acknowledged one cycle later, mapped or not.
      s_d.ack       = cfg_write | cfg_read;
      // Read data is captured on a read only and holds until the next one.
      if (rd_ctrl) begin
         s_d.rdata = ctrl_view;
      end else if (rd_stat) begin
         s_d.rdata = stat_view;
      end else if (cfg_read) begin
         s_d.rdata = '0; // Unmapped offsets read as zero.
      end

      // Lane one holds only reserved bits, so it changes nothing.
      // fields written independently
      if (wr_lane3) begin
         s_d.enable = wr_enable;
         s_d.neg_start = wr_enable;
         s_d.ident = wr_ident;
      end
      if (wr_lane2) begin
         s_d.sel = wr_sel;
         s_d.load = wr_load;
      end
      if (wr_lane0) begin
         s_d.map = wr_map;
      end

      // A modification in the cycle of the clear wins, so no table change is lost.
      // clear on load completion
      if (load_done) begin
         s_d.tstat = 1'b0;
      end
      if (table_modified) begin
         s_d.tstat = 1'b1;
      end
   end

   // Synchronous reset loads the documented values; triggers, acknowledge and read data clear.
   // reset to documented value
   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_q        <= '0;
         s_q.enable <= VC1RC_CTRL_RESET[VC1RC_EN_BIT];
         s_q.ident  <= VC1RC_ID_RESET;
         s_q.sel    <= VC1RC_SEL_RR;
         s_q.map    <= VC1RC_MAP_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // The negotiation itself lies outside this block; a fixed busy window stands in for it,
   // and a second enable write while the window runs starts it over.
   // pending while negotiating
   vc1rc_pulse_timer #(
      .CYCLES (VC1RC_NEG_CYCLES)
   ) u_neg_timer (
      .clk    (clk),
      .resetn (resetn),
      .start  (s_q.neg_start),
      .busy   (neg_busy),
      .done   ()
   );

   // Table load takes a few cycles to copy the entries.
   // A new load request during a copy restarts it; the status flag clears when the last copy ends.
   vc1rc_pulse_timer #(
      .CYCLES (VC1RC_LOAD_CYCLES)
   ) u_load_timer (
      .clk    (clk),
      .resetn (resetn),
      .start  (s_q.load),
      .busy   (),
      .done   (load_done)
   );

   // Outputs come straight from the state register or, for pending, the negotiation timer register, so every data output is a flip-flop.
   // one bit per class
   assign traffic_class_map         = s_q.map;
   assign channel_enable            = s_q.enable;
   assign channel_identifier        = s_q.ident;
   assign arbitration_scheme_select = s_q.sel;
   assign negotiation_pending       = neg_busy;
   assign table_status              = s_q.tstat;
   assign table_load_strobe         = s_q.load;
   assign cfg_rdata                 = s_q.rdata;
   assign cfg_ack                   = s_q.ack;
endmodule

// ### vc1rc_pkg.sv
// Package with offsets, field positions, reset values and timing counts of the channel control block.
package vc1rc_pkg;
   localparam logic [11:0] VC1RC_CTRL_OFFSET    = 12'h170;
   localparam logic [11:0] VC1RC_STATUS_OFFSET  = 12'h174;
   localparam logic [31:0] VC1RC_CTRL_RESET     = 32'h0100_0000;
   localparam int          VC1RC_EN_BIT         = 31;
   localparam int          VC1RC_ID_LSB         = 24;
   localparam int          VC1RC_SEL_LSB        = 17;
   localparam int          VC1RC_LOAD_BIT       = 16;
   localparam int          VC1RC_PEND_BIT       = 17;
   localparam int          VC1RC_TSTAT_BIT      = 16;
   localparam logic [2:0]  VC1RC_ID_RESET       = 3'h1;
   localparam logic [2:0]  VC1RC_SEL_RR         = 3'h0;
   localparam logic [2:0]  VC1RC_SEL_TWRR128    = 3'h4;
   localparam logic [7:0]  VC1RC_MAP_RESET      = 8'h00;
   localparam logic [7:0]  VC1RC_MAP_WMASK      = 8'hfe;
   localparam int          VC1RC_NEG_CYCLES     = 16;
   localparam int          VC1RC_LOAD_CYCLES    = 4;
endpackage

// ### vc1rc_pulse_timer.sv
// Small busy timer: a start pulse holds busy for a fixed number of cycles.
module vc1rc_pulse_timer
   import vc1rc_pkg::*;
#(
   parameter int CYCLES = 4
) (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic start,
   output logic      busy,
   output logic      done
);
   typedef struct packed {
      logic [7:0] count;
      logic       busy;
      logic       done;
   } vc1rc_tmr_t;

   vc1rc_tmr_t s_q;
   vc1rc_tmr_t s_d;

   // Counts down while busy; a new start restarts the count.
   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      if (start) begin
         s_d.busy  = 1'b1;
         s_d.count = 8'(CYCLES - 1);
      end else if (s_q.busy) begin
         if (s_q.count == 8'h00) begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
         end else begin
            s_d.count = s_q.count - 8'h01;
         end
      end
   end

   // State register with synchronous reset.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign busy = s_q.busy;
   assign done = s_q.done;
endmodule

// ### vc1rc_control_chk.sv
// Checker with concurrent properties for the second channel control register.
module vc1rc_chk
   import vc1rc_pkg::*;
(
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        cfg_write,
   input wire logic        cfg_read,
   input wire logic [11:0] cfg_addr,
   input wire logic [3:0]  cfg_byte_en,
   input wire logic [31:0] cfg_wdata,
   input wire logic [31:0] cfg_rdata,
   input wire logic        cfg_ack,
   input wire logic        table_modified,
   input wire logic        channel_enable,
   input wire logic [7:0]  traffic_class_map,
   input wire logic        negotiation_pending,
   input wire logic        table_status,
   input wire logic        table_load_strobe
);
   // Write aimed at the control word.
   wire logic wr_ctl = cfg_write && cfg_addr == VC1RC_CTRL_OFFSET;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_ack; cfg_write || cfg_read |=> cfg_ack; endproperty
   a_ack: assert property (p_ack) else $error("ack missing");
   property p_en; wr_ctl && cfg_byte_en[3] |=> channel_enable == $past(cfg_wdata[31]); endproperty
   a_en: assert property (p_en) else $error("enable not written");
   property p_pend; wr_ctl && cfg_byte_en[3] && cfg_wdata[31] |=> ##1 negotiation_pending [*8]; endproperty
   a_pend: assert property (p_pend) else $error("pending not held");
   property p_map0; !traffic_class_map[0]; endproperty
   a_map0: assert property (p_map0) else $error("class zero mapped");
   property p_load; wr_ctl && cfg_byte_en[2] && cfg_wdata[16] |=> table_load_strobe; endproperty
   a_load: assert property (p_load) else $error("load strobe missing");
   property p_cause; table_load_strobe |-> $past(wr_ctl && cfg_byte_en[2] && cfg_wdata[16]); endproperty
   a_cause: assert property (p_cause) else $error("load strobe without write");
   property p_rsvd; cfg_read && cfg_addr == VC1RC_CTRL_OFFSET |=> (cfg_rdata & 32'h78f1_ff01) == 32'h0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("read-only bits nonzero");
   property p_tstat; table_modified |=> table_status; endproperty
   a_tstat: assert property (p_tstat) else $error("table status not set");
   c_pend: cover property (negotiation_pending);
   c_load: cover property (table_load_strobe ##5 !table_status);
   c_read: cover property (cfg_read ##1 cfg_ack);
endmodule
bind vc1rc_control vc1rc_chk u_chk (.clk(clk), .resetn(resetn), .cfg_write(cfg_write), .cfg_read(cfg_read),
   .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
   .table_modified(table_modified), .channel_enable(channel_enable), .traffic_class_map(traffic_class_map),
   .negotiation_pending(negotiation_pending), .table_status(table_status), .table_load_strobe(table_load_strobe));

// ### tb_top.sv
// Self-checking bench for the second channel control register.
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_top
   import vc1rc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        cfg_write = 1'b0;
   logic        cfg_read = 1'b0;
   logic [11:0] cfg_addr = 12'h000;
   logic [3:0]  cfg_byte_en = 4'h0;
   logic [31:0] cfg_wdata = 32'h0;
   logic        table_modified = 1'b0;
   logic [31:0] cfg_rdata, d;
   logic        cfg_ack, channel_enable, negotiation_pending, table_status, table_load_strobe;
   logic [2:0]  channel_identifier, arbitration_scheme_select;
   logic [7:0]  traffic_class_map;
   int          errors = 0;
   int          checks = 0;
   int          strobes = 0;
   int          m_en = 0, m_id = 1, m_sel = 0, m_map = 0, n, s0;
   vc1rc_control dut (.clk(clk), .resetn(resetn), .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_addr(cfg_addr),
      .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
      .table_modified(table_modified), .channel_enable(channel_enable), .channel_identifier(channel_identifier),
      .arbitration_scheme_select(arbitration_scheme_select), .traffic_class_map(traffic_class_map),
      .negotiation_pending(negotiation_pending), .table_status(table_status), .table_load_strobe(table_load_strobe));
   // Clock of 5 ns and a count of load pulses.
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) if (table_load_strobe === 1'b1) strobes++;
   // Expected control word from the model fields.
   function automatic logic [31:0] exp_ctl();
      return (32'(m_en) << 31) | (32'(m_id) << 24) | (32'(m_sel) << 17) | 32'(m_map);
   endfunction
   // One write, then an idle cycle; the model follows the byte enables.
   task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] v);
      cfg_write = 1'b1;
      cfg_addr = a;
      cfg_byte_en = be;
      cfg_wdata = v;
      @(negedge clk);
      cfg_write = 1'b0;
      `CHK("wr ack", 1'b1, cfg_ack)
      if (a == VC1RC_CTRL_OFFSET && be[3]) m_en = v[31];
      if (a == VC1RC_CTRL_OFFSET && be[3]) m_id = v[26:24];
      if (a == VC1RC_CTRL_OFFSET && be[2]) m_sel = v[19:17];
      if (a == VC1RC_CTRL_OFFSET && be[0]) m_map = v[7:0] & 8'hfe;
      @(negedge clk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      cfg_read = 1'b1;
      cfg_addr = a;
      @(negedge clk);
      cfg_read = 1'b0;
      `CHK("rd ack", 1'b1, cfg_ack)
      `CHK("rdata", e, cfg_rdata)
      @(negedge clk);
   endtask
   task automatic stop_test();
      $display("Checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #20000;
      errors++;
      stop_test();
   end
   initial begin
      void'($urandom(91));
      repeat (20) @(negedge clk);
      resetn = 1'b1;
      rd(VC1RC_CTRL_OFFSET, VC1RC_CTRL_RESET);
      rd(VC1RC_STATUS_OFFSET, 32'h0);
      // random legal writes with random byte enables.
      for (n = 0; n < 24; n++) begin
         d = $urandom;
         d[26:24] = 3'($urandom_range(7, 1));
         d[19:17] = $urandom_range(1) ? VC1RC_SEL_TWRR128 : VC1RC_SEL_RR;
         wr(VC1RC_CTRL_OFFSET, 4'($urandom), d);
         rd(VC1RC_CTRL_OFFSET, exp_ctl());
         `CHK("map", m_map[7:0], traffic_class_map)
         `CHK("id", m_id[2:0], channel_identifier)
         `CHK("sel", m_sel[2:0], arbitration_scheme_select)
         `CHK("en", m_en[0], channel_enable)
      end
      repeat (20) @(negedge clk);
      wr(VC1RC_CTRL_OFFSET, 4'h8, 32'h8100_0000);
      `CHK("pending start", 1'b1, negotiation_pending)
      n = 0;
      repeat (20) begin
         n += int'(negotiation_pending);
         @(negedge clk);
      end
      `CHK("pending", 16, n)
      table_modified = 1'b1;
      @(negedge clk);
      table_modified = 1'b0;
      rd(VC1RC_STATUS_OFFSET, 32'h0001_0000);
      s0 = strobes;
      wr(VC1RC_CTRL_OFFSET, 4'h4, 32'h0001_0000 | (32'(m_sel) << 17));
      `CHK("tstat busy", 1'b1, table_status)
      repeat (VC1RC_LOAD_CYCLES) @(negedge clk);
      `CHK("tstat held", 1'b1, table_status)
      @(negedge clk);
      `CHK("tstat", 1'b0, table_status)
      `CHK("strobes", 1, strobes - s0)
      rd(VC1RC_CTRL_OFFSET, exp_ctl());
      wr(12'h178, 4'hf, 32'hffff_ffff);
      rd(12'h178, 32'h0);
      rd(VC1RC_CTRL_OFFSET, exp_ctl());
      stop_test();
   end
endmodule
